// >>> dv/accumulator_alu_and_branch_tb_top.sv
/* Self-checking bench for exec_unit: command sequences via the host model.
   Assumes the host model tasks and the unit's include file. */
`default_nettype none
`include "exec_unit_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module accumulator_alu_and_branch_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  din = 2'b01;
  logic [9:0]  adc [4] = '{10'h3ff, 10'h12e, 10'h200, 10'h001};
  logic [3:0]  errs = 4'h0;
  logic        psel, penable, pwrite, pready, pslverr, first_general_output, second_general_output, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pc;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [7:0]  ops [12] = '{`OP_ADD, `OP_SUB, `OP_MUL, `OP_DIV, `OP_MOD, `OP_AND,
                            `OP_OR, `OP_XOR, `OP_NOT, `OP_LOAD, `OP_DIV, `OP_MOD};
  logic [31:0] opd [12] = '{7, 7, 32'hffffec78, 7, 7, 32'hf0, 3, 32'hff, 0,
                            32'h12345678, 0, 0};
  logic [31:0] expv [12] = '{32'hffffffa3, 32'hffffff95, 32'h0007a120, 32'hfffffff2,
                             32'hfffffffe, 32'h90, 32'hffffff9f, 32'hffffff63, 32'h63,
                             32'h12345678, 32'hffffff9c, 32'hffffff9c};
  logic [31:0] cmpv [3] = '{5, 3, 9};
  logic [7:0]  taken [3] = '{8'ha5, 8'h3a, 8'hca};
  always #25 clk = ~clk;
  exec_unit u_exec_unit (
    .ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .first_general_input_in(din[0]),
    .second_general_input_in(din[1]), .first_adc_in(adc[0]), .second_adc_in(adc[1]),
    .supply_adc_in(adc[2]), .temp_adc_in(adc[3]), .timeout_error_flag_in(errs[0]),
    .external_alarm_flag_in(errs[1]), .deviation_error_flag_in(errs[2]),
    .position_error_flag_in(errs[3]), .first_general_output_out(first_general_output),
    .second_general_output_out(second_general_output), .pc_out(pc), .irq_out(irq));
  host_model u_host_model (
    .ref_clk_in(clk), .pready_in(pready), .prdata_in(prdata), .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata));
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    u_host_model.rd(a, r);
    `CHK(r, e)
  endtask
  task automatic jump_chk(input logic [7:0] code, input logic t);
    u_host_model.wr(`REG_PC, 32'h0);
    u_host_model.cmd(`INSTR_COND_JUMP, code, 8'h00, 32'h55);
    `CHK(pc, t ? 16'h0055 : 16'h0001)
  endtask
  // Ceiling well above the roughly 1100 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    u_host_model.wr(`REG_IRQ_MASK, 32'h0);
    u_host_model.cmd(`INSTR_ARITH, `OP_LOAD, 8'h00, 32'd3);
    u_host_model.cmd(`INSTR_ARITH, `OP_MUL, 8'h00, 32'hffffec78);
    rdchk(`REG_ACCUM, 32'hffffc568);
    rdchk(`REG_REPLY_HEAD, 32'h6413);
    for (int i = 0; i < 12; i++) begin
      u_host_model.cmd(`INSTR_ARITH, `OP_LOAD, 8'h00, 32'hffffff9c);
      u_host_model.cmd(`INSTR_ARITH, ops[i], 8'h00, opd[i]);
      rdchk(`REG_ACCUM, expv[i]);
    end
    u_host_model.cmd(`INSTR_ARITH, `OP_LOAD, 8'h00, 32'h0bad);
    for (int p = 0; p < 4; p++) begin
      u_host_model.cmd(`INSTR_INPUT_READ, p[7:0], `BANK_ANALOG_IN, 32'h0);
      rdchk(`REG_REPLY_VALUE, {22'h0, adc[p]});
    end
    for (int p = 0; p < 2; p++) begin
      u_host_model.cmd(`INSTR_INPUT_READ, p[7:0], `BANK_DIGITAL_IN, 32'h0);
      rdchk(`REG_REPLY_VALUE, {31'h0, din[p]});
    end
    rdchk(`REG_ACCUM, 32'h0bad);
    for (int v = 1; v < 3; v++) begin
      u_host_model.cmd(`INSTR_OUTPUT_SET, `PORT_0, `BANK_DIGITAL_OUT, {31'h0, v[0]});
      u_host_model.cmd(`INSTR_OUTPUT_SET, `PORT_1, `BANK_DIGITAL_OUT, {31'h0, v[1]});
      `CHK(first_general_output, v[0])
      `CHK(second_general_output, v[1])
      for (int p = 0; p < 2; p++) begin
        u_host_model.cmd(`INSTR_INPUT_READ, p[7:0], `BANK_DIGITAL_OUT, 32'h0);
        rdchk(`REG_REPLY_VALUE, {31'h0, v[p]});
      end
    end
    // Compare and jump only from a stored program
    u_host_model.mode(1'b1);
    u_host_model.cmd(`INSTR_INPUT_READ, `PORT_3, `BANK_ANALOG_IN, 32'h0);
    rdchk(`REG_ACCUM, {22'h0, adc[3]});
    for (int c = 0; c < 3; c++) begin
      u_host_model.cmd(`INSTR_ARITH, `OP_LOAD, 8'h00, 32'd5);
      u_host_model.cmd(`INSTR_COMPARE, 8'h00, 8'h00, cmpv[c]);
      rdchk(`REG_FLAGS, 32'h1 << c);
      u_host_model.cmd(`INSTR_ARITH, `OP_LOAD, 8'h00, cmpv[c]);
      for (int k = 0; k < 8; k++) begin
        jump_chk(k[7:0], taken[c][k]);
      end
    end
    for (int e = 0; e < 4; e++) begin
      errs <= 4'h1 << e;
      repeat (6) @(posedge clk);
      for (int j = 0; j < 4; j++) begin
        jump_chk(8'h08 + j[7:0], j == e);
      end
    end
    errs <= 4'h0;
    u_host_model.rd(`REG_IRQ_STATUS, r);
    `CHK(r, 32'h3)
    `CHK(irq, 1'b0)
    u_host_model.wr(`REG_IRQ_MASK, 32'h1 << `IRQ_BAD_CMD);
    u_host_model.cmd(8'h30, 8'h00, 8'h00, 32'h0);
    `CHK(irq, 1'b1)
    u_host_model.rd(`REG_REPLY_HEAD, r);
    `CHK(r[15:8], `STATUS_BAD_CMD)
    u_host_model.rd(`REG_IRQ_STATUS, r);
    `CHK(r[`IRQ_BAD_CMD], 1'b1)
    `CHK(irq, 1'b0)
    rdchk(`REG_IRQ_STATUS, 32'h0);
    u_host_model.xfer(1'b0, 12'h030, 32'h0, r, err);
    `CHK(err, 1'b1)
    `CHK(r, 32'h0)
    print_verdict();
  end
endmodule // accumulator_alu_and_branch_tb_top
`default_nettype wire

// >>> dv/exec_unit_properties.sv
/* Concurrent checks on the exec_unit ports, bound in below.
   Assumes the unit's include file and zero-wait APB. */
`default_nettype none
`include "exec_unit_defines.vh"
module exec_unit_properties (
  input wire logic        ref_clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        first_general_output_out,
  input wire logic        second_general_output_out,
  input wire logic [15:0] pc_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire        acc_w = psel_in && penable_in;
  wire        wr_w  = acc_w && pwrite_in;
  wire        go_w  = wr_w && paddr_in == `REG_CONTROL && pwdata_in[`CTRL_GO];
  wire        pcw_w = wr_w && paddr_in == `REG_PC;
  wire [15:0] pcd_w = pwdata_in[15:0];
  property p_ready; pready_out; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr;
    acc_w |-> pslverr_out == (paddr_in > 12'h024 || paddr_in[1:0] != 2'b00);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_rdata; !(acc_w && !pwrite_in) |-> prdata_out == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("prdata not zero when idle");
  property p_reset;
    $rose(rst_n_in) |-> pc_out == 16'h0 && !irq_out && !first_general_output_out
      && !second_general_output_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_pc_load; pcw_w |=> pc_out == $past(pcd_w); endproperty
  a_pc_load: assert property (p_pc_load) else $error("pc write lost");
  property p_pc_hold; !pcw_w && !go_w |=> $stable(pc_out); endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved idle");
  property p_out_hold;
    !go_w |=> $stable(first_general_output_out) && $stable(second_general_output_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved idle");
  property p_irq_rise; $rose(irq_out) |-> $past(wr_w); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without write");
  property p_irq_fall; $fell(irq_out) |-> $past(acc_w); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
  property p_irq_mask;
    wr_w && paddr_in == `REG_IRQ_MASK && pwdata_in[2:0] == 3'h0 |=> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
  c_go: cover property (go_w);
  c_irq: cover property ($rose(irq_out));
  c_err: cover property (acc_w && pslverr_out);
endmodule // exec_unit_properties
bind exec_unit exec_unit_properties u_exec_unit_properties (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .first_general_output_out(first_general_output_out),
  .second_general_output_out(second_general_output_out), .pc_out(pc_out),
  .irq_out(irq_out));
`default_nettype wire

// >>> dv/host_model.sv
/* Host side model: APB master tasks that send commands to the unit.
   Assumes tasks are entered just after a rising clock edge. */
`default_nettype none
`include "exec_unit_defines.vh"
module host_model (
  input  wire logic        ref_clk_in,
  input  wire logic        pready_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pslverr_in,
  output var  logic        psel_out,
  output var  logic        penable_out,
  output var  logic        pwrite_out,
  output var  logic [11:0] paddr_out,
  output var  logic [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic standalone_reg = 1'b0;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    do @(posedge ref_clk_in); while (pready_in !== 1'b1);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    // Inverted on release so a stale bus never looks valid
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic mode(input logic s);
    standalone_reg = s;
    wr(`REG_CONTROL, {31'h0, s});
  endtask
  task automatic cmd(input logic [7:0] ins, input logic [7:0] typ,
                     input logic [7:0] bank, input logic [31:0] val);
    wr(`REG_CMD_HEAD, {ins, typ, bank, 8'h00});
    wr(`REG_CMD_VALUE, val);
    wr(`REG_CONTROL, {30'h0, 1'b1, standalone_reg});
  endtask
endmodule // host_model
`default_nettype wire

// >>> rtl/accum_alu.v
/*
 * Combinational accumulator arithmetic for the arithmetic instruction.
 * Assumes the caller registers the result; the divider is large but purely
 * combinational, traded for a fixed one-cycle execution.
 */
`default_nettype none
`include "exec_unit_defines.vh"

module accum_alu (
  input  wire [7:0]  op_in,
  input  wire [31:0] accum_in,
  input  wire [31:0] operand_in,
  output reg  [31:0] result_out
);

  wire signed [31:0] acc_s = accum_in;
  wire signed [31:0] opd_s = operand_in;
  wire               opd_zero = (operand_in == 32'h0000_0000);
  wire signed [63:0] prod_full = acc_s * opd_s;

  always @* begin
    case (op_in)
      `OP_ADD:  result_out = accum_in + operand_in;
      `OP_SUB:  result_out = accum_in - operand_in;
      `OP_MUL:  result_out = prod_full[31:0];
      // Zero divisor keeps the accumulator [RQ17]
      `OP_DIV:  result_out = opd_zero ? acc_s : acc_s / opd_s;
      `OP_MOD:  result_out = opd_zero ? acc_s : acc_s % opd_s;
      `OP_AND:  result_out = accum_in & operand_in;
      `OP_OR:   result_out = accum_in | operand_in;
      `OP_XOR:  result_out = accum_in ^ operand_in;
      `OP_NOT:  result_out = ~accum_in;
      `OP_LOAD: result_out = operand_in;
      default:  result_out = accum_in;
    endcase // [RQ6]
  end

endmodule // accum_alu
`default_nettype wire

// >>> rtl/exec_unit.v
/*
 * APB-reached execution unit: arithmetic, compare, conditional jump,
 * input-read of banks 0 to 2 and output-set of bank 2.
 * Assumes a 20 MHz clock, synchronous active-low reset, inputs from pins
 * or a converter in another domain, and an external program sequencer
 * that reads the program counter.
 */
// The register offsets and register access over APB were chosen for this implementation.
`default_nettype none
`include "exec_unit_defines.vh"

// How it works
// RQ1 - Bank 1 ports 0 and 1 return the two general input conversions, 10 bits
// RQ2 - Bank 1 port 2 returns raw supply reading, port 3 raw temperature reading
// RQ3 - General inputs read as digital levels in bank 0 and analog in bank 1
// RQ4 - Bank 2 ports 0 and 1 return held state of the two general outputs
// RQ5 - Instruction 19 combines accumulator with value operand, result back to accumulator
// RQ6 - Type selects add, sub, mul, div, mod, and, or, xor, invert, load
// RQ7 - Arithmetic in direct mode replies status 100, value is don't care
// RQ8 - Instruction 20 compares accumulator with operand and sets status flags
// RQ9 - Instruction 21 loads program counter when condition holds, else steps on
// RQ10 - Jump codes 0 to 7 test zero through lower-or-equal on compare flags
// RQ11 - Jump codes 8 to 11 test timeout, alarm, deviation, position error flags
// RQ12 - Jump tests stored compare flags, never the live accumulator
// RQ13 - Host issues conditional jump only in standalone program execution
// RQ14 - Compare is for standalone use; arithmetic also accepted in direct mode
// RQ15 - Standalone input-read loads accumulator; direct mode only replies
// RQ16 - Value and accumulator are 32-bit two's complement, high byte first
// RQ17 - Divide or modulo by zero leaves the accumulator unchanged
module exec_unit (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire        first_general_input_in,
  input  wire        second_general_input_in,
  input  wire [9:0]  first_adc_in,
  input  wire [9:0]  second_adc_in,
  input  wire [9:0]  supply_adc_in,
  input  wire [9:0]  temp_adc_in,
  input  wire        timeout_error_flag_in,
  input  wire        external_alarm_flag_in,
  input  wire        deviation_error_flag_in,
  input  wire        position_error_flag_in,
  output reg         first_general_output_out,
  output reg         second_general_output_out,
  output reg  [15:0] pc_out,
  output wire        irq_out
);

  // Command and state registers
  reg [31:0] cmd_head_reg;
  reg [31:0] cmd_value_reg;
  reg        standalone_reg;
  reg [31:0] accum_reg;
  reg [2:0]  flags_reg;
  reg [7:0]  reply_status_reg;
  reg [7:0]  reply_instr_reg;
  reg [31:0] reply_value_reg;

  // Interrupt status and mask
  reg [`IRQ_WIDTH-1:0] irq_status_reg;
  reg [`IRQ_WIDTH-1:0] irq_mask_reg;

  // Three-stage synchronisers for pin-side levels
  reg [1:0]  din_s1_reg;
  reg [1:0]  din_s2_reg;
  reg [1:0]  din_s3_reg;
  reg [1:0]  din_reg;
  reg [3:0]  err_s1_reg;
  reg [3:0]  err_s2_reg;
  reg [3:0]  err_s3_reg;
  reg [3:0]  err_reg;
  reg [39:0] adc_s1_reg;
  reg [39:0] adc_s2_reg;
  reg [39:0] adc_s3_reg;
  reg [39:0] adc_reg;

  wire [7:0] instr = cmd_head_reg[31:24];
  wire [7:0] typ   = cmd_head_reg[23:16];
  wire [7:0] bank  = cmd_head_reg[15:8];
  // Operand arrives high byte first, kept as one signed word [RQ16]
  wire [31:0] operand = cmd_value_reg;

  // APB decode
  wire apb_access = psel_in & penable_in;
  wire apb_wr     = apb_access & pwrite_in;
  wire apb_rd     = apb_access & ~pwrite_in;

  function addr_known;
    input [11:0] a;
    begin
      case (a)
        `REG_CMD_HEAD,
        `REG_CMD_VALUE,
        `REG_CONTROL,
        `REG_ACCUM,
        `REG_PC,
        `REG_FLAGS,
        `REG_REPLY_HEAD,
        `REG_REPLY_VALUE,
        `REG_IRQ_STATUS,
        `REG_IRQ_MASK: addr_known = 1'b1;
        default:       addr_known = 1'b0;
      endcase
    end
  endfunction

  // No wait states: every access ends in its first cycle
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access & ~addr_known(paddr_in);

  wire go = apb_wr & (paddr_in == `REG_CONTROL) & pwdata_in[`CTRL_GO];

  // Input synchronisers: accept a change once stages two and three agree
  always @(posedge ref_clk_in) begin
    din_s1_reg <= {second_general_input_in, first_general_input_in};
    din_s2_reg <= din_s1_reg;
    din_s3_reg <= din_s2_reg;

    err_s1_reg <= {position_error_flag_in, deviation_error_flag_in,
                   external_alarm_flag_in, timeout_error_flag_in};
    err_s2_reg <= err_s1_reg;
    err_s3_reg <= err_s2_reg;

    adc_s1_reg <= {temp_adc_in, supply_adc_in, second_adc_in, first_adc_in};
    adc_s2_reg <= adc_s1_reg;
    adc_s3_reg <= adc_s2_reg;
    // Chain runs through reset, so levels are settled at release
    if (!rst_n_in) begin
      din_reg <= 2'b00;
      err_reg <= 4'h0;
      adc_reg <= 40'h00_0000_0000;
    end else begin
      if (din_s2_reg == din_s3_reg) din_reg <= din_s3_reg;
      if (err_s2_reg == err_s3_reg) err_reg <= err_s3_reg;
      // Whole word only moves when stable, avoiding torn converter values
      if (adc_s2_reg == adc_s3_reg) adc_reg <= adc_s3_reg;
    end
  end

  // Input-read selection
  reg [31:0] read_value;
  reg        read_ok;
  always @* begin
    read_value = 32'h0000_0000;
    read_ok    = 1'b1;
    case (bank)
      `BANK_DIGITAL_IN: begin
        case (typ)
          `PORT_0: read_value = {31'h0, din_reg[0]}; // [RQ3]
          `PORT_1: read_value = {31'h0, din_reg[1]}; // [RQ3]
          default: read_ok = 1'b0;
        endcase
      end
      `BANK_ANALOG_IN: begin
        case (typ)
          `PORT_0: read_value = {22'h0, adc_reg[9:0]};   // [RQ1] [RQ3]
          `PORT_1: read_value = {22'h0, adc_reg[19:10]}; // [RQ1] [RQ3]
          `PORT_2: read_value = {22'h0, adc_reg[29:20]}; // [RQ2]
          `PORT_3: read_value = {22'h0, adc_reg[39:30]}; // [RQ2]
          default: read_ok = 1'b0;
        endcase
      end
      `BANK_DIGITAL_OUT: begin
        case (typ)
          `PORT_0: read_value = {31'h0, first_general_output_out};  // [RQ4]
          `PORT_1: read_value = {31'h0, second_general_output_out}; // [RQ4]
          default: read_ok = 1'b0;
        endcase
      end
      default: read_ok = 1'b0;
    endcase
  end

  // Jump condition decode on stored flags, not the live accumulator
  function cond_met;
    input [7:0] code;
    input [2:0] f;
    input [3:0] e;
    begin
      case (code)
        `COND_NULL_RESULT: cond_met = f[`FLAG_ZERO];                       // [RQ10] [RQ12]
        `COND_NOT_ZERO:    cond_met = ~f[`FLAG_ZERO];                      // [RQ10]
        `COND_SAME_VALUE:  cond_met = f[`FLAG_ZERO];                       // [RQ10]
        `COND_DIFFERS:     cond_met = ~f[`FLAG_ZERO];                      // [RQ10]
        `COND_GREATER:     cond_met = f[`FLAG_GREATER];                    // [RQ10]
        `COND_AT_LEAST:    cond_met = f[`FLAG_GREATER] | f[`FLAG_ZERO];    // [RQ10]
        `COND_BELOW:       cond_met = f[`FLAG_LOWER];                      // [RQ10]
        `COND_AT_MOST:     cond_met = f[`FLAG_LOWER] | f[`FLAG_ZERO];      // [RQ10]
        `COND_TIMEOUT:     cond_met = e[0];                                // [RQ11]
        `COND_ALARM:       cond_met = e[1];                                // [RQ11]
        `COND_DEVIATION:   cond_met = e[2];                                // [RQ11]
        `COND_POSITION:    cond_met = e[3];                                // [RQ11]
        default:           cond_met = 1'b0;
      endcase
    end
  endfunction

  wire [31:0] alu_result;
  accum_alu u_alu (
    .op_in      (typ),        // [RQ6] [RQ17]
    .accum_in   (accum_reg),
    .operand_in (operand),
    .result_out (alu_result)
  );

  wire signed [31:0] acc_s = accum_reg;
  wire signed [31:0] opd_s = operand;
  wire               jump_taken = cond_met(typ, flags_reg, err_reg);
  wire               known_cond = (typ <= `COND_POSITION);

  // Event pulses for the interrupt status
  reg [`IRQ_WIDTH-1:0] irq_events;
  reg                  bad_cmd;
  always @* begin
    bad_cmd = 1'b0;
    case (instr)
      `INSTR_ARITH:      bad_cmd = (typ > `OP_LOAD);
      `INSTR_COMPARE:    bad_cmd = 1'b0;
      `INSTR_COND_JUMP:  bad_cmd = ~known_cond;
      `INSTR_INPUT_READ: bad_cmd = ~read_ok;
      `INSTR_OUTPUT_SET: bad_cmd = ~(bank == `BANK_DIGITAL_OUT &&
                                     (typ == `PORT_0 || typ == `PORT_1));
      default:           bad_cmd = 1'b1;
    endcase
    irq_events = 3'b000;
    irq_events[`IRQ_DONE]       = go;
    irq_events[`IRQ_JUMP_TAKEN] = go & (instr == `INSTR_COND_JUMP) & jump_taken;
    irq_events[`IRQ_BAD_CMD]    = go & bad_cmd;
  end

  // A status read clears it; same-cycle events survive
  wire irq_read = apb_rd & (paddr_in == `REG_IRQ_STATUS);

  // Execution and register writes
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      cmd_head_reg              <= 32'h0000_0000;
      cmd_value_reg             <= 32'h0000_0000;
      standalone_reg            <= 1'b0;
      accum_reg                 <= `ACCUM_RESET;
      flags_reg                 <= 3'b000;
      pc_out                    <= `PC_RESET;
      reply_status_reg          <= 8'h00;
      reply_instr_reg           <= 8'h00;
      reply_value_reg           <= 32'h0000_0000;
      first_general_output_out  <= 1'b0;
      second_general_output_out <= 1'b0;
      irq_mask_reg              <= 3'b000;
    end else begin
      // Standalone bit takes effect from the next command
      if (apb_wr) begin
        case (paddr_in)
          `REG_CMD_HEAD:  cmd_head_reg   <= pwdata_in;
          `REG_CMD_VALUE: cmd_value_reg  <= pwdata_in;
          `REG_CONTROL:   standalone_reg <= pwdata_in[`CTRL_STANDALONE];
          `REG_PC:        pc_out         <= pwdata_in[15:0];
          `REG_IRQ_MASK:  irq_mask_reg   <= pwdata_in[`IRQ_WIDTH-1:0];
          default: ;
        endcase
      end
      if (go) begin
        reply_instr_reg  <= instr;
        reply_status_reg <= bad_cmd ? `STATUS_BAD_CMD : `STATUS_OK; // [RQ7]
        reply_value_reg  <= 32'h0000_0000;
        // A refused command only updates the reply
        if (!bad_cmd) begin
          case (instr)
            `INSTR_ARITH: begin
              accum_reg       <= alu_result; // [RQ5]
              reply_value_reg <= operand;    // [RQ7]
              if (standalone_reg) pc_out <= pc_out + 16'h0001;
            end
            `INSTR_COMPARE: begin
              // Flags held until the next compare [RQ8] [RQ12]
              flags_reg[`FLAG_ZERO]    <= (acc_s == opd_s);
              flags_reg[`FLAG_GREATER] <= (acc_s > opd_s);
              flags_reg[`FLAG_LOWER]   <= (acc_s < opd_s);
              if (standalone_reg) pc_out <= pc_out + 16'h0001;
            end
            `INSTR_COND_JUMP: begin
              // Meant for program execution; acted on as given [RQ13]
              if (jump_taken) pc_out <= operand[15:0];       // [RQ9]
              else            pc_out <= pc_out + 16'h0001;   // [RQ9]
            end
            `INSTR_INPUT_READ: begin
              reply_value_reg <= read_value;
              if (standalone_reg) begin
                accum_reg <= read_value; // [RQ15]
                pc_out    <= pc_out + 16'h0001;
              end
            end
            `INSTR_OUTPUT_SET: begin
              if (typ == `PORT_0) first_general_output_out  <= operand[0];
              else                second_general_output_out <= operand[0];
              if (standalone_reg) pc_out <= pc_out + 16'h0001;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Sticky status: new event wins over the clearing read
  always @(posedge ref_clk_in) begin
    if (!rst_n_in)
      irq_status_reg <= 3'b000;
    else if (irq_read)
      irq_status_reg <= irq_events;
    else
      irq_status_reg <= irq_status_reg | irq_events;
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // Read mux, combinational within the access phase
  always @* begin
    prdata_out = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr_in)
        `REG_CMD_HEAD:    prdata_out = cmd_head_reg;
        `REG_CMD_VALUE:   prdata_out = cmd_value_reg;
        `REG_CONTROL:     prdata_out = {31'h0, standalone_reg};
        `REG_ACCUM:       prdata_out = accum_reg;
        `REG_PC:          prdata_out = {16'h0000, pc_out};
        `REG_FLAGS:       prdata_out = {25'h0, err_reg, flags_reg};
        `REG_REPLY_HEAD:  prdata_out = {16'h0000, reply_status_reg, reply_instr_reg};
        `REG_REPLY_VALUE: prdata_out = reply_value_reg;
        `REG_IRQ_STATUS:  prdata_out = {29'h0, irq_status_reg};
        `REG_IRQ_MASK:    prdata_out = {29'h0, irq_mask_reg};
        default:          prdata_out = 32'h0000_0000;
      endcase
    end
  end

endmodule // exec_unit
`default_nettype wire

// >>> rtl/exec_unit_defines.vh
/*
 * Constants for the accumulator, compare, branch and input-read unit:
 * instruction numbers, operation and condition codes, bank and port numbers,
 * APB register offsets, bit positions and reset values.
 * Assumes inclusion by bare name from the rtl files of this unit.
 */
`ifndef EXEC_UNIT_DEFINES_VH
`define EXEC_UNIT_DEFINES_VH

// Instruction numbers
`define INSTR_OUTPUT_SET   8'h0e
`define INSTR_INPUT_READ   8'h0f
`define INSTR_ARITH        8'h13
`define INSTR_COMPARE      8'h14
`define INSTR_COND_JUMP    8'h15

// Arithmetic operation codes
`define OP_ADD  8'h00
`define OP_SUB  8'h01
`define OP_MUL  8'h02
`define OP_DIV  8'h03
`define OP_MOD  8'h04
`define OP_AND  8'h05
`define OP_OR   8'h06
`define OP_XOR  8'h07
`define OP_NOT  8'h08
`define OP_LOAD 8'h09

// Jump condition codes
`define COND_NULL_RESULT 8'h00
`define COND_NOT_ZERO    8'h01
`define COND_SAME_VALUE  8'h02
`define COND_DIFFERS     8'h03
`define COND_GREATER     8'h04
`define COND_AT_LEAST    8'h05
`define COND_BELOW       8'h06
`define COND_AT_MOST     8'h07
`define COND_TIMEOUT     8'h08
`define COND_ALARM       8'h09
`define COND_DEVIATION   8'h0a
`define COND_POSITION    8'h0b

// Banks and ports
`define BANK_DIGITAL_IN  8'h00
`define BANK_ANALOG_IN   8'h01
`define BANK_DIGITAL_OUT 8'h02
`define PORT_0           8'h00
`define PORT_1           8'h01
`define PORT_2           8'h02
`define PORT_3           8'h03

// Reply status
`define STATUS_OK        8'h64
`define STATUS_BAD_CMD   8'h02

// APB register byte offsets
`define REG_CMD_HEAD     12'h000
`define REG_CMD_VALUE    12'h004
`define REG_CONTROL      12'h008
`define REG_ACCUM        12'h00c
`define REG_PC           12'h010
`define REG_FLAGS        12'h014
`define REG_REPLY_HEAD   12'h018
`define REG_REPLY_VALUE  12'h01c
`define REG_IRQ_STATUS   12'h020
`define REG_IRQ_MASK     12'h024

// Control bits
`define CTRL_STANDALONE  0
`define CTRL_GO          1

// Flag register bits
`define FLAG_ZERO        0
`define FLAG_GREATER     1
`define FLAG_LOWER       2

// Interrupt status bits
`define IRQ_DONE         0
`define IRQ_JUMP_TAKEN   1
`define IRQ_BAD_CMD      2
`define IRQ_WIDTH        3

`define PC_RESET         16'h0000
`define ACCUM_RESET      32'h0000_0000

`endif
